// File: rtl/gdfm_top.sv
/*
 * Fault manager of a three-phase gate driver: supply, thermal and
 * overload protection, fault and warning pins, status bits, enable sequence.
 * Assumes raw pins are asynchronous; serial reset and config come from
 * logic on I_MCLK.
 */
`default_nettype none
// Function
// - gates low while main or gate-drive supply is under threshold
// - main undervoltage: ignore serial commands, serial registers take defaults
// - gate-supply overvoltage: gates and charge pump off, latched, enable transition clears
// - overvoltage shows on fault pin and status, not warning; survives quick resets
// - warning pin reports both by default, or thermal only, or overcurrent only; code still shows thermal shutdown on it in every setting
// - thermal warning: no action, no latch, status and default warning pin
// - thermal shutdown latches gates and pump off, no self recovery
// - after cooling, enable reset or serial gate reset restores the driver
// - thermal shutdown shows on fault pin, warning pin and status together
// - serial access and settings kept during thermal shutdown if main supply ok
// - open-drain fault pin low on any shutdown fault
// - fault pin released once internal enable is up and driver ready
// - warning pin shows overcurrent and thermal events without shutdown
// - current limit: only tripped fet limited, warning and phase status only
// - latch mode: phase forced off, latched, fault, warning and status
// - gates held low from power-up until enabled
// - rising enable starts operation; pwm accepted only without errors
// - enable rise: power-up, clear absent latched faults, clear status
// - enable fall: gates off at once, full shutdown after 10 us low
// - serial gate reset clears driver faults except gate-supply overvoltage, and status; rest keeps running
module gdfm_top
  import gdfm_pkg::*;
#(
  parameter int OCW_CYCLES = OCW_CYC
)
(
  input wire logic I_MCLK,
  input wire logic I_ARST_N,
  input wire logic I_MAIN_UNDER,
  input wire logic I_GATE_UNDER,
  input wire logic I_GATE_OVER,
  input wire logic I_LOGIC_UNDER,
  input wire logic I_THERM_WARN,
  input wire logic I_THERM_SD,
  input wire logic I_EN_GATE,
  input wire logic [5:0] I_OC_DET,
  input wire logic [2:0] I_PWM_HI,
  input wire logic [2:0] I_PWM_LO,
  input wire logic I_GATE_RESET,
  input wire gdfm_ocm_t I_OC_MODE,
  input wire gdfm_wsel_t I_WARN_SEL,
  output logic [2:0] O_GH,
  output logic [2:0] O_GL,
  output logic O_FAULT_N_OUT,
  output logic O_FAULT_N_OE,
  output logic O_WARN_N_OUT,
  output logic O_WARN_N_OE,
  output logic O_CP_EN,
  output logic O_SERIAL_EN,
  output logic O_REGS_DEFAULT,
  output logic O_ST_FAULT,
  output logic O_ST_MAIN_UV,
  output logic O_ST_GATE_UV,
  output logic O_ST_GATE_OV,
  output logic O_ST_OTW,
  output logic O_ST_OTSD,
  output logic [5:0] O_ST_OC
);
  localparam int OCW_W = $clog2(OCW_CYCLES + 1);

  generate
    if (OCW_CYCLES < 1)
      $error("OCW_CYCLES must be at least one");
  endgenerate

  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic main_uv;
  logic gate_uv;
  logic gate_ov;
  logic logic_uv;
  logic thermal_warning;
  logic ot_sd;
  logic en_s;
  logic [5:0] oc_s;
  logic [2:0] pwm_hi_s;
  logic [2:0] pwm_lo_s;
  logic logic_uv_d;
  gdfm_en_st_t state;
  logic [EN_HOLD_W-1:0] hold_cnt;
  logic en_rise;
  logic full_rise;
  logic gate_rst;
  logic drv_clr;
  logic st_clr;
  logic gate_ov_lat;
  logic otsd_lat;
  logic [2:0] ph_lat;
  logic [2:0] gh_w;
  logic [2:0] gl_w;
  logic allow;
  logic shut_any;
  logic oc_evt;
  logic [OCW_W-1:0] ocw_tmr;
  logic ocw_act;
  logic ot_part;
  logic oc_part;
  logic next_warn;
  logic [5:0] next_st_oc;

  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser for every pin input
  always_ff @(posedge I_MCLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= {I_PWM_LO, I_PWM_HI, I_OC_DET, I_EN_GATE, I_THERM_SD, I_THERM_WARN,
                I_LOGIC_UNDER, I_GATE_OVER, I_GATE_UNDER, I_MAIN_UNDER};
      sync2 <= sync1;
    end
  end

  assign {pwm_lo_s, pwm_hi_s, oc_s, en_s, ot_sd, thermal_warning, logic_uv, gate_ov, gate_uv, main_uv} = sync2;

  ////////////////////////////////////////////////////////////////////////////
  // enable sequencing: run, short low hold, full shutdown
  always_ff @(posedge I_MCLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      state <= ST_DOWN;
      hold_cnt <= '0;
    end
    else
    begin
      unique case (state)
        ST_DOWN:
          if (en_s)
            state <= ST_RUN;
        ST_RUN:
          if (!en_s)
          begin
            state <= ST_HOLD;
            hold_cnt <= '0;
          end
        ST_HOLD:
          if (en_s)
            state <= ST_RUN;
          else if (hold_cnt == EN_HOLD_W'(EN_HOLD_CYC - 1))
            state <= ST_DOWN;
          else
            hold_cnt <= hold_cnt + 1'b1;
        default:
          state <= ST_DOWN;
      endcase
    end
  end

  assign en_rise = en_s && state != ST_RUN;
  assign full_rise = en_s && state == ST_DOWN;
  assign gate_rst = I_GATE_RESET && !main_uv;
  assign drv_clr = en_rise || gate_rst;

  always_ff @(posedge I_MCLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      logic_uv_d <= RST_LOW;
    else
      logic_uv_d <= logic_uv;
  end

  // status clears: enable rise, serial reset, logic supply recovery, main uv
  assign st_clr = drv_clr || (logic_uv_d && !logic_uv) || main_uv;

  ////////////////////////////////////////////////////////////////////////////
  // latched shutdown faults; a new event wins over a clear
  always_ff @(posedge I_MCLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      gate_ov_lat <= RST_LOW;
    else
      gate_ov_lat <= (gate_ov_lat && !(full_rise && !gate_ov)) || gate_ov;
  end

  always_ff @(posedge I_MCLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      otsd_lat <= RST_LOW;
    else
      otsd_lat <= (otsd_lat && !(drv_clr && !ot_sd)) || ot_sd;
  end

  ////////////////////////////////////////////////////////////////////////////
  // phases
  assign allow = state == ST_RUN && !main_uv && !gate_uv && !logic_uv
                 && !gate_ov_lat && !otsd_lat;

  genvar g;
  generate
    for (g = 0; g < NUM_PHASES; g++)
    begin : gen_ph
      gdfm_phase_if pif ();
      assign pif.pwm_hi = pwm_hi_s[g];
      assign pif.pwm_lo = pwm_lo_s[g];
      assign pif.oc_hs = oc_s[2*g] && I_OC_MODE != OCM_OFF;
      assign pif.oc_ls = oc_s[2*g+1] && I_OC_MODE != OCM_OFF;
      assign gh_w[g] = pif.gh;
      assign gl_w[g] = pif.gl;
      assign ph_lat[g] = pif.lat;
      gdfm_phase u_ph (
        .i_clk(I_MCLK),
        .i_arst_n(I_ARST_N),
        .p(pif),
        .i_mode(I_OC_MODE),
        .i_allow(allow),
        .i_clr(drv_clr)
      );
    end
  endgenerate

  assign O_GH = gh_w;
  assign O_GL = gl_w;

  ////////////////////////////////////////////////////////////////////////////
  // overcurrent report timer, restarted by each new event
  assign oc_evt = |oc_s && I_OC_MODE != OCM_OFF;

  always_ff @(posedge I_MCLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      ocw_tmr <= '0;
    else if (oc_evt)
      ocw_tmr <= OCW_W'(OCW_CYCLES);
    else if (ocw_tmr != '0)
      ocw_tmr <= ocw_tmr - 1'b1;
  end

  assign ocw_act = ocw_tmr != '0 || |ph_lat;
  assign ot_part = (thermal_warning || otsd_lat) && I_WARN_SEL != WS_OC;
  assign oc_part = ocw_act && I_WARN_SEL != WS_OT;
  assign next_warn = ot_part || oc_part || otsd_lat;

  assign shut_any = main_uv || gate_uv || logic_uv || gate_ov_lat || otsd_lat || |ph_lat;

  ////////////////////////////////////////////////////////////////////////////
  // open-drain pins, oe high while pulling low
  always_ff @(posedge I_MCLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      O_FAULT_N_OE <= RST_HIGH;
      O_FAULT_N_OUT <= RST_LOW;
      O_WARN_N_OE <= RST_LOW;
      O_WARN_N_OUT <= RST_HIGH;
    end
    else
    begin
      O_FAULT_N_OE <= shut_any || state != ST_RUN;
      O_FAULT_N_OUT <= !(shut_any || state != ST_RUN);
      O_WARN_N_OE <= next_warn;
      O_WARN_N_OUT <= !next_warn;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      O_CP_EN <= RST_LOW;
      O_SERIAL_EN <= RST_LOW;
      O_REGS_DEFAULT <= RST_HIGH;
    end
    else
    begin
      O_CP_EN <= state != ST_DOWN && !gate_ov_lat && !otsd_lat;
      O_SERIAL_EN <= !main_uv;
      O_REGS_DEFAULT <= main_uv;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status bits
  assign next_st_oc = (st_clr ? RST_OC : O_ST_OC) | (oc_evt && !main_uv ? oc_s : RST_OC);

  always_ff @(posedge I_MCLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      O_ST_OC <= RST_OC;
      O_ST_FAULT <= RST_LOW;
      O_ST_MAIN_UV <= RST_LOW;
      O_ST_GATE_UV <= RST_LOW;
      O_ST_GATE_OV <= RST_LOW;
      O_ST_OTW <= RST_LOW;
      O_ST_OTSD <= RST_LOW;
    end
    else
    begin
      O_ST_OC <= next_st_oc;
      O_ST_FAULT <= !main_uv && (gate_uv || gate_ov_lat || otsd_lat || |ph_lat);
      O_ST_MAIN_UV <= main_uv;
      O_ST_GATE_UV <= !main_uv && gate_uv;
      O_ST_GATE_OV <= !main_uv && gate_ov_lat;
      O_ST_OTW <= !main_uv && thermal_warning;
      O_ST_OTSD <= !main_uv && otsd_lat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_short_low;
    state == ST_RUN && !en_s ##1 state == ST_HOLD && en_s;
  endsequence

  sequence s_hold_expired;
    state == ST_HOLD && !en_s && hold_cnt == EN_HOLD_W'(EN_HOLD_CYC - 1);
  endsequence

  a_uv_gates_low: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
    (main_uv || gate_uv) |=> (O_GH == RST_GATES && O_GL == RST_GATES)) else $error("gate on under uv");
  a_ov_survives_quick: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
    gate_ov_lat ##0 s_short_low |=> gate_ov_lat) else $error("ov cleared by quick reset");
  a_ov_fault_pin: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
    gate_ov_lat && !thermal_warning && !ocw_act && !otsd_lat |=> O_FAULT_N_OE && !O_WARN_N_OE) else $error("ov pins");
  a_otw_status: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
    (thermal_warning && !main_uv) |=> O_ST_OTW) else $error("thermal warning not in status");
  a_otsd_report: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
    otsd_lat |=> (O_FAULT_N_OE && O_WARN_N_OE && O_GH == RST_GATES)) else $error("otsd not reported");
  a_otsd_sticky: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
    otsd_lat && !drv_clr |=> otsd_lat) else $error("otsd recovered alone");
  a_hold_timeout: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
    s_hold_expired |=> state == ST_DOWN ##1 !O_CP_EN) else $error("no full shutdown");
  a_quick_back: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
    s_short_low |=> state == ST_RUN) else $error("quick reset lost");
  a_ready_release: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
    (state == ST_RUN && !shut_any) |=> !O_FAULT_N_OE) else $error("fault pin stuck");
  a_logic_uv_pin: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
    logic_uv |=> (O_FAULT_N_OE && O_GL == RST_GATES)) else $error("logic uv not shown");
  a_main_uv_regs: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
    main_uv |=> (O_REGS_DEFAULT && !O_SERIAL_EN && O_ST_OC == RST_OC)) else $error("serial not reset");
endmodule
`default_nettype wire

// File: rtl/gdfm_pkg.sv
/*
 * Shared constants and types for the gate driver fault manager.
 * Assumes a single 125 MHz clock feeding every module of the block.
 */
`default_nettype none
package gdfm_pkg;
  localparam int CLK_MHZ = 125;
  // full gate-enable shutdown after a low level of this length
  localparam int EN_HOLD_NS = 10000;
  localparam int EN_HOLD_CYC = (EN_HOLD_NS * CLK_MHZ) / 1000;
  localparam int EN_HOLD_W = $clog2(EN_HOLD_CYC);
  // overcurrent report time on the warning pin
  localparam int OCW_NS = 64000;
  localparam int OCW_CYC = (OCW_NS * CLK_MHZ) / 1000;
  localparam int NUM_PHASES = 3;
  localparam int SYNC_W = 7 + 4 * NUM_PHASES;
  localparam logic RST_LOW = 1'b0;
  localparam logic RST_HIGH = 1'b1;
  localparam logic [2:0] RST_GATES = 3'h0;
  localparam logic [5:0] RST_OC = 6'h00;

  typedef enum logic [1:0] {
    OCM_LIMIT = 2'b00,
    OCM_LATCH = 2'b01,
    OCM_REPORT = 2'b10,
    OCM_OFF = 2'b11
  } gdfm_ocm_t;

  typedef enum logic [1:0] {
    WS_BOTH = 2'b00,
    WS_OT = 2'b01,
    WS_OC = 2'b10,
    WS_ALSO_BOTH = 2'b11
  } gdfm_wsel_t;

  typedef enum logic [1:0] {
    ST_DOWN = 2'b00,
    ST_RUN = 2'b01,
    ST_HOLD = 2'b10
  } gdfm_en_st_t;
endpackage
`default_nettype wire

// File: rtl/gdfm_phase_if.sv
/*
 * Signals between the fault manager and one half-bridge phase.
 * Assumes all members are on the block clock.
 */
`default_nettype none
interface gdfm_phase_if;
  logic pwm_hi;
  logic pwm_lo;
  logic oc_hs;
  logic oc_ls;
  logic gh;
  logic gl;
  logic lat;
  modport drv (output pwm_hi, output pwm_lo, output oc_hs, output oc_ls, input gh, input gl, input lat);
  modport ph (input pwm_hi, input pwm_lo, input oc_hs, input oc_ls, output gh, output gl, output lat);
endinterface
`default_nettype wire

// File: rtl/gdfm_phase.sv
/*
 * One half-bridge: gate outputs, current limiting and latched overload.
 * Assumes synchronised PWM and overcurrent inputs from the fault manager.
 */
`default_nettype none
module gdfm_phase
  import gdfm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  gdfm_phase_if.ph p,
  input wire gdfm_ocm_t i_mode,
  input wire logic i_allow,
  input wire logic i_clr
);
  logic hs_cut;
  logic ls_cut;
  logic oc_now;
  logic next_gh;
  logic next_gl;

  assign oc_now = p.oc_hs | p.oc_ls;

  ////////////////////////////////////////////////////////////////////////////
  // cycle-by-cycle limit: only the tripped fet, until its pwm ends
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      hs_cut <= RST_LOW;
      ls_cut <= RST_LOW;
    end
    else
    begin
      hs_cut <= (hs_cut & p.pwm_hi) | (i_mode == OCM_LIMIT && p.oc_hs);
      ls_cut <= (ls_cut & p.pwm_lo) | (i_mode == OCM_LIMIT && p.oc_ls);
    end
  end

  // latch mode: whole phase off, cleared only when overload has gone
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      p.lat <= RST_LOW;
    else
      p.lat <= (p.lat & ~(i_clr & ~oc_now)) | (i_mode == OCM_LATCH && oc_now);
  end

  ////////////////////////////////////////////////////////////////////////////
  // six-input pwm; both high means both off
  always_comb
  begin
    next_gh = i_allow & ~p.lat & ~hs_cut & p.pwm_hi & ~p.pwm_lo;
    next_gl = i_allow & ~p.lat & ~ls_cut & p.pwm_lo & ~p.pwm_hi;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      p.gh <= RST_LOW;
      p.gl <= RST_LOW;
    end
    else
    begin
      p.gh <= next_gh;
      p.gl <= next_gl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_latch_kills_phase: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    p.lat |=> (!p.gh && !p.gl)) else $error("latched phase still driving");
  a_limit_only_hs: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_mode == OCM_LIMIT && p.oc_hs) ##1 p.pwm_hi |=> !p.gh) else $error("limited fet on");
  a_no_shoot: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !(p.gh && p.gl)) else $error("both gates high");
endmodule
`default_nettype wire

// File: tb/gdfm_mcu_model.sv
/*
 * Model of the motor-control microcontroller that drives gate enable, PWM and
 * the gate reset command, and watches the open-drain fault pin.
 * Assumes bench commands change just after a rising edge of the clock.
 */
`default_nettype none
module gdfm_mcu_model
(
  input wire logic i_clk,
  input wire logic i_en_cmd,
  input wire logic [2:0] i_hi_cmd,
  input wire logic [2:0] i_lo_cmd,
  input wire logic i_rst_cmd,
  input wire logic i_fault_pin_n,
  output logic o_en_gate,
  output logic [2:0] o_pwm_hi,
  output logic [2:0] o_pwm_lo,
  output logic o_gate_reset,
  output logic o_fault_seen
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // outputs move just after the edge, like a real port register
  always @(posedge i_clk)
  begin
    o_en_gate <= #1 i_en_cmd;
    o_pwm_hi <= #1 i_hi_cmd;
    o_pwm_lo <= #1 i_lo_cmd;
    o_gate_reset <= #1 i_rst_cmd;
    o_fault_seen <= #1 ~i_fault_pin_n;
  end
endmodule
`default_nettype wire

// File: tb/gdfm_top_tb.sv
/*
 * Self-checking bench of the fault manager: start-up, then table of level
 * faults, thermal, overvoltage, enable timing and overload cases.
 * Assumes a pull-up on the fault pin and the short warning timer of 20 cycles.
 */
`default_nettype none
module gdfm_top_tb
  import gdfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [3:0] cond;
    gdfm_wsel_t sel;
    gdfm_ocm_t md;
    logic [5:0] oc;
    logic [15:0] exp;
  } gdfm_row_t;

  logic clk, arst_n, main_u, gate_u, gate_o, logic_u, tw, tsd, en_cmd, rst_cmd;
  logic [5:0] oc, st_oc;
  logic [2:0] hi_cmd, lo_cmd, gh, gl, pwm_hi, pwm_lo;
  gdfm_ocm_t mode;
  gdfm_wsel_t wsel;
  logic en_gate, gate_reset, fault_seen, fault_oe, fault_out, warn_oe, warn_out, cp_en, ser_en, reg_def;
  logic st_fault, st_muv, st_guv, st_gov, st_otw, st_otsd;
  int n_errors = 0;
  int samples_checked = 0;
  wire fault_pin_n;
  assign fault_pin_n = fault_oe ? 1'h0 : 1'h1;

  // exp: gh, fault oe, warn oe, serial en, regs default, main uv, gate uv, otw, oc status
  gdfm_row_t rows [10] = '{
    '{4'h8, WS_BOTH, OCM_LIMIT, 6'h00, 16'h1300},
    '{4'h4, WS_BOTH, OCM_LIMIT, 6'h00, 16'h1480},
    '{4'h2, WS_BOTH, OCM_LIMIT, 6'h00, 16'h1400},
    '{4'h1, WS_BOTH, OCM_LIMIT, 6'h00, 16'hec40},
    '{4'h1, WS_OT, OCM_LIMIT, 6'h00, 16'hec40},
    '{4'h1, WS_OC, OCM_LIMIT, 6'h00, 16'he440},
    '{4'h1, WS_ALSO_BOTH, OCM_LIMIT, 6'h00, 16'hec40},
    '{4'h0, WS_BOTH, OCM_REPORT, 6'h01, 16'hec01},
    '{4'h0, WS_OT, OCM_REPORT, 6'h01, 16'he401},
    '{4'h0, WS_BOTH, OCM_OFF, 6'h01, 16'he400}};

  gdfm_top #(.OCW_CYCLES(20)) u_dut (.I_MCLK(clk), .I_ARST_N(arst_n), .I_MAIN_UNDER(main_u),
    .I_GATE_UNDER(gate_u), .I_GATE_OVER(gate_o), .I_LOGIC_UNDER(logic_u), .I_THERM_WARN(tw),
    .I_THERM_SD(tsd), .I_EN_GATE(en_gate), .I_OC_DET(oc), .I_PWM_HI(pwm_hi), .I_PWM_LO(pwm_lo),
    .I_GATE_RESET(gate_reset), .I_OC_MODE(mode), .I_WARN_SEL(wsel), .O_GH(gh), .O_GL(gl),
    .O_FAULT_N_OUT(fault_out), .O_FAULT_N_OE(fault_oe), .O_WARN_N_OUT(warn_out), .O_WARN_N_OE(warn_oe),
    .O_CP_EN(cp_en), .O_SERIAL_EN(ser_en), .O_REGS_DEFAULT(reg_def), .O_ST_FAULT(st_fault),
    .O_ST_MAIN_UV(st_muv), .O_ST_GATE_UV(st_guv), .O_ST_GATE_OV(st_gov), .O_ST_OTW(st_otw),
    .O_ST_OTSD(st_otsd), .O_ST_OC(st_oc));

  gdfm_mcu_model u_mcu (.i_clk(clk), .i_en_cmd(en_cmd), .i_hi_cmd(hi_cmd), .i_lo_cmd(lo_cmd),
    .i_rst_cmd(rst_cmd), .i_fault_pin_n(fault_pin_n), .o_en_gate(en_gate), .o_pwm_hi(pwm_hi),
    .o_pwm_lo(pwm_lo), .o_gate_reset(gate_reset), .o_fault_seen(fault_seen));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic pulse_reset;
    rst_cmd = 1'h1;
    step(1);
    rst_cmd = 1'h0;
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    #200000;
    n_errors++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {arst_n, main_u, gate_u, gate_o, logic_u, tw, tsd, en_cmd, rst_cmd} = 9'h000;
    oc = 6'h00;
    hi_cmd = 3'h7;
    lo_cmd = 3'h0;
    mode = OCM_LIMIT;
    wsel = WS_BOTH;
    step(5);
    check("reset outputs", 10'h009, {gh, gl, fault_oe, warn_oe, cp_en, reg_def});
    step(15);
    arst_n = 1'h1;
    step(10);
    check("before enable", 10'h008, {gh, gl, fault_oe, warn_oe, cp_en, reg_def});
    check("fault pin", 16'h0001, {fault_out, fault_seen});
    en_cmd = 1'h1;
    step(8);
    check("start-up", 16'h003a, {gh, fault_oe, cp_en, fault_seen});
    $display("test start-up done");

    foreach (rows[i])
    begin
      {main_u, gate_u, logic_u, tw} = rows[i].cond;
      wsel = rows[i].sel;
      mode = rows[i].md;
      oc = rows[i].oc;
      step(8);
      check("table row", rows[i].exp,
        {gh, fault_oe, warn_oe, ser_en, reg_def, st_muv, st_guv, st_otw, st_oc});
      {main_u, gate_u, logic_u, tw} = 4'h0;
      oc = 6'h00;
      step(30);
      pulse_reset();
      step(8);
    end
    $display("test table done");

    wsel = WS_OC;
    tsd = 1'h1;
    step(8);
    check("thermal shutdown", 9'h036, {gh, fault_oe, warn_oe, cp_en, ser_en, st_otsd, warn_out});
    tsd = 1'h0;
    step(8);
    check("thermal latched", 9'h036, {gh, fault_oe, warn_oe, cp_en, ser_en, st_otsd, warn_out});
    pulse_reset();
    step(8);
    check("thermal cleared", 9'h1cd, {gh, fault_oe, warn_oe, cp_en, ser_en, st_otsd, warn_out});
    wsel = WS_BOTH;
    $display("test thermal done");

    gate_o = 1'h1;
    step(8);
    check("overvoltage", 9'h027, {gh, fault_oe, warn_oe, cp_en, st_gov, st_fault, warn_out});
    gate_o = 1'h0;
    step(8);
    pulse_reset();
    step(8);
    check("ov after gate reset", 5'h02, {gh, fault_oe, cp_en});
    en_cmd = 1'h0;
    step(20);
    en_cmd = 1'h1;
    step(10);
    check("ov after quick toggle", 5'h02, {gh, fault_oe, cp_en});
    en_cmd = 1'h0;
    step(1);
    en_cmd = 1'h1;
    step(10);
    check("ov after one-cycle low", 5'h02, {gh, fault_oe, cp_en});
    en_cmd = 1'h0;
    step(1300);
    en_cmd = 1'h1;
    step(10);
    check("ov after full toggle", 5'h1d, {gh, fault_oe, cp_en});
    $display("test overvoltage done");

    en_cmd = 1'h0;
    step(8);
    check("enable fall", 5'h03, {gh, fault_oe, cp_en});
    step(1200);
    check("pump kept in hold", 5'h03, {gh, fault_oe, cp_en});
    step(60);
    check("pump off after hold", 5'h02, {gh, fault_oe, cp_en});
    en_cmd = 1'h1;
    step(10);
    check("restart", 5'h1d, {gh, fault_oe, cp_en});
    $display("test enable timing done");

    mode = OCM_LIMIT;
    oc = 6'h01;
    step(8);
    check("current limit", 11'h641, {gh, fault_oe, warn_oe, st_oc});
    oc = 6'h00;
    step(8);
    check("limit held", 3'h6, gh);
    hi_cmd = 3'h6;
    step(2);
    hi_cmd = 3'h7;
    step(40);
    check("limit released", 5'h1c, {gh, fault_oe, warn_oe});
    $display("test current limit done");

    mode = OCM_LATCH;
    oc = 6'h08;
    step(8);
    check("latch mode", 14'h28c9, {gh, gl, fault_oe, warn_oe, st_oc});
    oc = 6'h00;
    step(8);
    check("latch kept", 14'h28c9, {gh, gl, fault_oe, warn_oe, st_oc});
    pulse_reset();
    step(30);
    check("latch cleared", 14'h3800, {gh, gl, fault_oe, warn_oe, st_oc});
    $display("test latch mode done");
    step(5);
    wrap_up();
  end
endmodule
`default_nettype wire
